// >>> pkg/dlb_pkg.sv
// Constants and types shared by the decorated load bit engine
package dlb_pkg;

    // ------------------------------------------------------------
    // Decoration decode
    // ------------------------------------------------------------
    localparam logic [1:0] DLB_SPACE_PERIPH = 2'h2;
    localparam logic [2:0] DLB_OP_SET_ONE = 3'h3;
    localparam logic DLB_OP_EXTRACT = 1'b1;
    localparam logic [31:0] DLB_SET_ONE_MASK = 32'hE00FFFFF;
    localparam logic [31:0] DLB_EXTRACT_MASK = 32'hE007FFFF;

    // ------------------------------------------------------------
    // Bus codes
    // ------------------------------------------------------------
    localparam logic [1:0] DLB_TRANS_IDLE = 2'h0;
    localparam logic [1:0] DLB_TRANS_NONSEQ = 2'h2;
    localparam logic [2:0] DLB_SIZE_BYTE = 3'h0;
    localparam logic [2:0] DLB_SIZE_HALF = 3'h1;
    localparam logic [2:0] DLB_SIZE_WORD = 3'h2;
    localparam logic [31:0] DLB_CONT_BYTE = 32'h000000FF;
    localparam logic [31:0] DLB_CONT_HALF = 32'h0000FFFF;
    localparam logic [31:0] DLB_CONT_WORD = 32'hFFFFFFFF;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] DLB_CTRL_OFS = 12'h000;
    localparam logic [11:0] DLB_STAT_OFS = 12'h004;
    localparam logic [11:0] DLB_SET_CNT_OFS = 12'h008;
    localparam logic [11:0] DLB_EXT_CNT_OFS = 12'h00C;
    localparam int DLB_CTRL_EN_BIT = 0;
    localparam logic DLB_CTRL_EN_RESET = 1'b1;
    localparam logic [31:0] DLB_CNT_RESET = 32'h00000000;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DLB_PASS,
        DLB_SET_READ,
        DLB_SET_WRITE,
        DLB_EXT_READ,
        DLB_EXT_RETURN
    } dlb_state_e;

endpackage

// >>> pkg/dlb_field_if.sv
// Carrier between the sequencer and the field arithmetic unit
interface dlb_field_if;
    logic [2:0] size;
    logic [1:0] laneOfs;
    logic [4:0] pos;
    logic [3:0] widthM1;
    logic [31:0] rdata;
    logic [31:0] heldField;
    logic setBit;
    logic [31:0] setWord;
    logic [31:0] maskedField;
    logic [31:0] alignedField;

    modport core (
        output size, laneOfs, pos, widthM1, rdata, heldField,
        input setBit, setWord, maskedField, alignedField
    );
    modport unit (
        input size, laneOfs, pos, widthM1, rdata, heldField,
        output setBit, setWord, maskedField, alignedField
    );
endinterface

// >>> verilog/dlb_field_unit.sv
// Bit and field arithmetic for decorated loads
module dlb_field_unit
    import dlb_pkg::*;
(
    // Operands and results
    dlb_field_if.unit f
);

    logic [4:0] laneShift;
    logic [31:0] contMask;
    logic [31:0] lane;
    logic [31:0] fieldMask;

    always_comb begin
        laneShift = 5'h00;
        contMask = DLB_CONT_WORD;
        case (f.size)
            DLB_SIZE_BYTE: begin
                laneShift = {f.laneOfs, 3'b000};
                contMask = DLB_CONT_BYTE;
            end
            DLB_SIZE_HALF: begin
                laneShift = {f.laneOfs[1], 4'h0};
                contMask = DLB_CONT_HALF;
            end
            default: begin
                laneShift = 5'h00;
                contMask = DLB_CONT_WORD;
            end
        endcase
        // Container moved down from its byte lanes
        lane = (f.rdata >> laneShift) & contMask;
        fieldMask = ((32'h1 << ({2'b00, f.widthM1} + 6'h01)) - 32'h1)
            << f.pos;
        f.setBit = lane[f.pos];
        f.setWord = f.rdata
            | (32'h1 << ({1'b0, f.pos} + {1'b0, laneShift}));
        // Container mask cuts a field that runs past the top
        f.maskedField = lane & fieldMask;
        f.alignedField = f.heldField >> f.pos;
    end

endmodule

// >>> verilog/dlb_bridge.sv
// Decorated load bit engine between core master and peripheral slaves
//
// The implementer's own choices: the APB interface to the registers and the address map.
module dlb_bridge
    import dlb_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Register bus
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Core facing bus
    input wire logic [31:0] mHaddr,
    input wire logic [1:0] mHtrans,
    input wire logic mHwrite,
    input wire logic [2:0] mHsize,
    input wire logic [31:0] mHwdata,
    output logic [31:0] mHrdata,
    output logic mHready,
    output logic mHresp,
    // Peripheral facing bus
    output logic [31:0] sHaddr,
    output logic [1:0] sHtrans,
    output logic sHwrite,
    output logic [2:0] sHsize,
    output logic [31:0] sHwdata,
    input wire logic [31:0] sHrdata,
    input wire logic sHready,
    input wire logic sHresp
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    dlb_state_e state_q;
    dlb_state_e state_d;
    logic enable_q;
    logic [31:0] setCnt_q;
    logic [31:0] extCnt_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] addr_q;
    logic [2:0] size_q;
    logic [4:0] pos_q;
    logic [3:0] widthM1_q;
    logic bit_q;
    logic [31:0] setWord_q;
    logic [31:0] field_q;
    logic passPhase;
    logic sizeOk;
    logic periph;
    logic decSet;
    logic decExt;
    logic [31:0] strippedAddr;
    logic [4:0] posDec;
    logic [3:0] widthDec;
    logic apbSetup;
    logic apbWrite;

    dlb_field_if fieldBus ();

    // ------------------------------------------------------------
    // Field arithmetic
    // ------------------------------------------------------------
    assign fieldBus.size = size_q;
    assign fieldBus.laneOfs = addr_q[1:0];
    assign fieldBus.pos = pos_q;
    assign fieldBus.widthM1 = widthM1_q;
    assign fieldBus.rdata = sHrdata;
    assign fieldBus.heldField = field_q;

    dlb_field_unit fieldUnit (
        .f (fieldBus)
    );

    // ------------------------------------------------------------
    // Decoration decode on the core address phase
    // ------------------------------------------------------------
    assign passPhase = (state_q == DLB_PASS)
        || (state_q == DLB_SET_WRITE) || (state_q == DLB_EXT_RETURN);
    assign sizeOk = (mHsize == DLB_SIZE_BYTE) || (mHsize == DLB_SIZE_HALF)
        || (mHsize == DLB_SIZE_WORD);
    assign periph = !mHaddr[31]
        && (mHaddr[30:29] == DLB_SPACE_PERIPH);
    assign decSet = enable_q && mHtrans[1] && !mHwrite && sizeOk
        && periph && (mHaddr[28:26] == DLB_OP_SET_ONE);
    assign decExt = enable_q && mHtrans[1] && !mHwrite && sizeOk
        && periph && (mHaddr[28] == DLB_OP_EXTRACT);

    always_comb begin
        posDec = 5'h00;
        widthDec = 4'h0;
        strippedAddr = mHaddr;
        if (decExt) begin
            strippedAddr = mHaddr & DLB_EXTRACT_MASK;
            case (mHsize)
                DLB_SIZE_BYTE: begin
                    posDec = {2'b00, mHaddr[25:23]};
                    widthDec = {1'b0, mHaddr[21:19]};
                end
                DLB_SIZE_HALF: begin
                    posDec = {1'b0, mHaddr[26:23]};
                    widthDec = mHaddr[22:19];
                end
                default: begin
                    posDec = mHaddr[27:23];
                    widthDec = mHaddr[22:19];
                end
            endcase
        end else if (decSet) begin
            strippedAddr = mHaddr & DLB_SET_ONE_MASK;
            case (mHsize)
                DLB_SIZE_BYTE: posDec = {2'b00, mHaddr[23:21]};
                DLB_SIZE_HALF: posDec = {1'b0, mHaddr[24:21]};
                default: posDec = mHaddr[25:21];
            endcase
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            DLB_SET_READ: begin
                if (sHready) begin
                    state_d = DLB_SET_WRITE;
                end
            end
            DLB_EXT_READ: begin
                if (sHready) begin
                    state_d = DLB_EXT_RETURN;
                end
            end
            DLB_PASS, DLB_SET_WRITE, DLB_EXT_RETURN: begin
                if (sHready) begin
                    if (decSet) begin
                        state_d = DLB_SET_READ;
                    end else if (decExt) begin
                        state_d = DLB_EXT_READ;
                    end else begin
                        state_d = DLB_PASS;
                    end
                end
            end
            default: state_d = DLB_PASS;
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state_q <= DLB_PASS;
        end else begin
            state_q <= state_d;
        end
    end

    // Capture stripped address and attributes in cycle x
    always_ff @(posedge clock) begin
        if (srst) begin
            addr_q <= 32'h00000000;
            size_q <= DLB_SIZE_WORD;
            pos_q <= 5'h00;
            widthM1_q <= 4'h0;
        end else if (passPhase && sHready && (decSet || decExt)) begin
            addr_q <= strippedAddr;
            size_q <= mHsize;
            pos_q <= posDec;
            widthM1_q <= widthDec;
        end
    end

    // Register read results in the first data phase
    always_ff @(posedge clock) begin
        if (srst) begin
            bit_q <= 1'b0;
            setWord_q <= 32'h00000000;
            field_q <= 32'h00000000;
        end else if (state_q == DLB_SET_READ && sHready) begin
            bit_q <= fieldBus.setBit;
            setWord_q <= fieldBus.setWord;
        end else if (state_q == DLB_EXT_READ && sHready) begin
            field_q <= fieldBus.maskedField;
        end
    end

    // ------------------------------------------------------------
    // Peripheral side address and data
    // ------------------------------------------------------------
    always_comb begin
        sHaddr = strippedAddr;
        sHtrans = mHtrans;
        sHwrite = mHwrite;
        sHsize = mHsize;
        case (state_q)
            DLB_SET_READ: begin
                sHaddr = addr_q;
                sHtrans = DLB_TRANS_NONSEQ;
                sHwrite = 1'b1;
                sHsize = size_q;
            end
            DLB_EXT_READ: begin
                sHaddr = addr_q;
                sHtrans = DLB_TRANS_IDLE;
                sHwrite = 1'b0;
                sHsize = size_q;
            end
            default: begin
                sHaddr = strippedAddr;
                sHtrans = mHtrans;
                sHwrite = mHwrite;
                sHsize = mHsize;
            end
        endcase
    end

    assign sHwdata = (state_q == DLB_SET_WRITE) ? setWord_q
        : mHwdata;

    // ------------------------------------------------------------
    // Core side answer
    // ------------------------------------------------------------
    always_comb begin
        case (state_q)
            DLB_SET_READ, DLB_EXT_READ: begin
                mHready = 1'b0;
                mHresp = 1'b0;
                mHrdata = sHrdata;
            end
            DLB_SET_WRITE: begin
                mHready = sHready;
                mHresp = sHresp;
                mHrdata = {31'h00000000, bit_q};
            end
            DLB_EXT_RETURN: begin
                mHready = sHready;
                mHresp = sHresp;
                mHrdata = fieldBus.alignedField;
            end
            default: begin
                mHready = sHready;
                mHresp = sHresp;
                mHrdata = sHrdata;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Register bus slave
    // ------------------------------------------------------------
    assign apbSetup = psel && !penable && !pready_q;
    assign apbWrite = psel && penable && pready_q && pwrite;

    always_ff @(posedge clock) begin
        if (srst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= apbSetup;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
            if (apbSetup) begin
                case (paddr)
                    DLB_CTRL_OFS: prdata_q <= {31'h00000000, enable_q};
                    DLB_STAT_OFS: begin
                        prdata_q <= {31'h00000000, !passPhase};
                    end
                    DLB_SET_CNT_OFS: prdata_q <= setCnt_q;
                    DLB_EXT_CNT_OFS: prdata_q <= extCnt_q;
                    default: pslverr_q <= 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            enable_q <= DLB_CTRL_EN_RESET;
        end else if (apbWrite && paddr == DLB_CTRL_OFS) begin
            enable_q <= pwdata[DLB_CTRL_EN_BIT];
        end
    end

    // Accepted decorated loads, counted at cycle x
    always_ff @(posedge clock) begin
        if (srst) begin
            setCnt_q <= DLB_CNT_RESET;
            extCnt_q <= DLB_CNT_RESET;
        end else if (passPhase && sHready) begin
            if (decSet) begin
                setCnt_q <= setCnt_q + 32'h00000001;
            end else if (decExt) begin
                extCnt_q <= extCnt_q + 32'h00000001;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

endmodule

// >>> tb/dlb_bridge_properties.sv
// Port-level checks for the decorated load bit engine
module dlb_bridge_properties
    import dlb_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Register bus
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    // Core side
    input wire logic [31:0] mHaddr,
    input wire logic [1:0] mHtrans,
    input wire logic mHwrite,
    input wire logic [2:0] mHsize,
    input wire logic [31:0] mHrdata,
    input wire logic mHready,
    input wire logic mHresp,
    // Slave side
    input wire logic [31:0] sHaddr,
    input wire logic [1:0] sHtrans,
    input wire logic sHwrite,
    input wire logic [2:0] sHsize,
    input wire logic [31:0] sHwdata,
    input wire logic [31:0] sHrdata,
    input wire logic sHready
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    // ----
    // Shadow of decode and phase
    // ----
    logic en_q;
    logic kindSet_q;
    logic [1:0] ph_q;
    logic [4:0] bit_q;
    logic [31:0] rd_q;
    logic take;
    logic isSet;
    logic isExt;
    logic [4:0] bitIdx;

    assign take = mHready && mHtrans[1];
    assign isSet = en_q && !mHwrite && mHsize <= DLB_SIZE_WORD
        && mHaddr[31:26] == 6'h13;
    assign isExt = en_q && !mHwrite && mHsize <= DLB_SIZE_WORD
        && mHaddr[31:28] == 4'h5;
    assign bitIdx = {mHaddr[1:0], 3'h0}
        + (mHaddr[25:21] & ((5'h08 << mHsize) - 5'h01));

    always_ff @(posedge clock) begin
        if (srst) begin
            en_q <= DLB_CTRL_EN_RESET;
        end else if (psel && penable && pready && pwrite
            && paddr == DLB_CTRL_OFS) begin
            en_q <= pwdata[DLB_CTRL_EN_BIT];
        end
    end

    // Phase 1 is the stalled first data phase, 2 the return
    always_ff @(posedge clock) begin
        if (srst) begin
            ph_q <= 2'h0;
        end else if (ph_q == 2'h1) begin
            if (sHready) begin
                ph_q <= 2'h2;
            end
        end else if (take && (isSet || isExt)) begin
            ph_q <= 2'h1;
        end else if (mHready) begin
            ph_q <= 2'h0;
        end
    end

    always_ff @(posedge clock) begin
        if (take) begin
            kindSet_q <= isSet;
            bit_q <= bitIdx;
        end
        if (ph_q == 2'h1) begin
            rd_q <= sHrdata;
        end
    end

    chk_set_strip: assert property (take && isSet |->
        sHaddr == (mHaddr & DLB_SET_ONE_MASK) && !sHwrite)
        else $error("set-one address not stripped");
    chk_ext_strip: assert property (take && isExt |->
        sHaddr == (mHaddr & DLB_EXTRACT_MASK) && !sHwrite)
        else $error("extract address not stripped");
    chk_set_reissue: assert property (take && isSet |=>
        sHwrite && sHtrans == DLB_TRANS_NONSEQ && sHaddr == $past(sHaddr))
        else $error("write phase not reissued");
    chk_ext_idle: assert property (ph_q == 2'h1 && !kindSet_q |->
        sHtrans == DLB_TRANS_IDLE)
        else $error("extract second address phase not idle");
    chk_stall_first: assert property (ph_q == 2'h1 |-> !mHready)
        else $error("core not stalled in first data phase");
    chk_wait_pass: assert property (ph_q != 2'h1 |->
        mHready == sHready)
        else $error("slave wait not passed to core");
    chk_set_bit: assert property (ph_q == 2'h2 && kindSet_q |->
        mHrdata == {31'h0, rd_q[bit_q]})
        else $error("set-one returned bit wrong");
    chk_set_wback: assert property (ph_q == 2'h2 && kindSet_q |->
        sHwdata == (rd_q | (32'h1 << bit_q)))
        else $error("set-one write-back word wrong");
    chk_pass_thru: assert property (take && !isSet && !isExt |->
        sHaddr == mHaddr && sHtrans == mHtrans && sHwrite == mHwrite)
        else $error("plain access altered");
    chk_size_pass: assert property (take |-> sHsize == mHsize)
        else $error("access size not forwarded");
    chk_size_reissue: assert property (take && isSet |=>
        sHsize == $past(mHsize))
        else $error("write phase size changed");
    chk_stall_resp: assert property (ph_q == 2'h1 |-> !mHresp)
        else $error("response raised while core stalled");
endmodule

bind dlb_bridge dlb_bridge_properties u_props (
    .clock(clock), .srst(srst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pready(pready), .mHaddr(mHaddr), .mHtrans(mHtrans),
    .mHwrite(mHwrite), .mHsize(mHsize), .mHrdata(mHrdata),
    .mHready(mHready), .mHresp(mHresp), .sHaddr(sHaddr),
    .sHtrans(sHtrans), .sHsize(sHsize),
    .sHwrite(sHwrite), .sHwdata(sHwdata), .sHrdata(sHrdata),
    .sHready(sHready)
);

// >>> tb/dlb_slave_model.sv
// Behavioural peripheral slave with word memory and wait states
module dlb_slave_model
    import dlb_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Bus from the bridge
    input wire logic [31:0] sHaddr,
    input wire logic [1:0] sHtrans,
    input wire logic sHwrite,
    input wire logic [31:0] sHwdata,
    output logic [31:0] sHrdata,
    output logic sHready,
    output logic sHresp,
    // Stall cycles per data phase
    input wire logic [3:0] waits
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] mem [16];
    logic [31:0] lastAddr;
    logic [31:0] noise = 32'hA5A5_0F0F;
    logic act;
    logic wr;
    logic [3:0] cnt;
    int writes = 0;

    // Read data is only valid in a read data phase
    assign sHready = !act || cnt == 4'h0;
    assign sHresp = 1'b0;
    assign sHrdata = (act && !wr) ? mem[lastAddr[5:2]] : noise;

    always @(posedge clock) begin
        noise <= ~noise;
        if (srst) begin
            act <= 1'b0;
            cnt <= 4'h0;
        end else if (!sHready) begin
            cnt <= cnt - 4'h1;
        end else begin
            if (act && wr) begin
                mem[lastAddr[5:2]] <= sHwdata;
                writes <= writes + 1;
            end
            act <= sHtrans[1];
            wr <= sHwrite;
            cnt <= waits;
            if (sHtrans[1]) begin
                lastAddr <= sHaddr;
            end
        end
    end
endmodule

// >>> tb/dlb_bridge_tb.sv
// Directed bench for the decorated load bit engine
`define CHK(g, e) checkVal(32'(g), 32'(e));
module dlb_bridge_tb
    import dlb_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock, srst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, mHaddr, mHwdata, mHrdata;
    logic [31:0] sHaddr, sHwdata, sHrdata;
    logic [1:0] mHtrans, sHtrans;
    logic [2:0] mHsize, sHsize;
    logic mHwrite, mHready, mHresp, sHwrite, sHready, sHresp;
    logic [3:0] waits;
    int mismatches = 0;
    int samplesChecked = 0;

    dlb_bridge u_dlb_bridge (
        .clock(clock), .srst(srst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mHaddr(mHaddr), .mHtrans(mHtrans), .mHwrite(mHwrite),
        .mHsize(mHsize), .mHwdata(mHwdata), .mHrdata(mHrdata),
        .mHready(mHready), .mHresp(mHresp), .sHaddr(sHaddr),
        .sHtrans(sHtrans), .sHwrite(sHwrite), .sHsize(sHsize),
        .sHwdata(sHwdata), .sHrdata(sHrdata), .sHready(sHready),
        .sHresp(sHresp)
    );
    dlb_slave_model u_slave (
        .clock(clock), .srst(srst), .sHaddr(sHaddr), .sHtrans(sHtrans),
        .sHwrite(sHwrite), .sHwdata(sHwdata), .sHrdata(sHrdata),
        .sHready(sHready), .sHresp(sHresp), .waits(waits)
    );

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic checkVal(input logic [31:0] g, input logic [31:0] e);
        samplesChecked++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic finishTest();
        if (mismatches == 0 && samplesChecked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic waitReady(input bit apb);
        int n;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while ((apb ? pready : mHready) !== 1'b1 && n < 64);
        if ((apb ? pready : mHready) !== 1'b1) begin
            mismatches++;
            finishTest();
        end
    endtask

    task automatic apbXfer(input logic [11:0] a, input logic wr,
        input logic [31:0] d, input logic [31:0] e, input logic err);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        waitReady(1'b1);
        `CHK(pslverr, err)
        if (!wr) begin
            `CHK(prdata, e)
        end
        @(posedge clock);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic ahbRead(input logic [31:0] a, input logic [2:0] sz,
        input logic [31:0] e);
        mHaddr <= a;
        mHtrans <= DLB_TRANS_NONSEQ;
        mHsize <= sz;
        waitReady(1'b0);
        @(posedge clock);
        mHtrans <= DLB_TRANS_IDLE;
        waitReady(1'b0);
        `CHK(mHrdata, e)
        @(posedge clock);
    endtask

    task automatic las(input logic [2:0] sz, input int ln, input int b);
        logic [31:0] m;
        int p;
        m = u_slave.mem[4];
        p = ln * 8 + (b & ((8 << sz) - 1));
        ahbRead(32'h4C10_0010 | ln | (b << 21), sz, (m >> p) & 1);
        @(negedge clock);
        `CHK(u_slave.lastAddr, 32'h4000_0010 | ln)
        `CHK(u_slave.mem[4], m | (32'h1 << p))
        @(posedge clock);
    endtask

    task automatic unsigned_field_extract(input logic [2:0] sz, input int ln, input int b,
        input int w);
        logic [63:0] m;
        int n;
        m = (u_slave.mem[5] >> (ln * 8)) & ((64'h1 << (8 << sz)) - 1);
        n = u_slave.writes;
        ahbRead(32'h5000_0014 | ln | (b << 23) | (w << 19), sz,
            32'((m >> b) & ((64'h1 << (w + 1)) - 1)));
        @(negedge clock);
        `CHK(u_slave.lastAddr, 32'h4000_0014 | ln)
        `CHK(u_slave.writes, n)
        @(posedge clock);
    endtask

    initial begin
        srst = 1'b1;
        {psel, penable, pwrite, mHwrite} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        mHaddr = 32'h0;
        mHwdata = 32'h0;
        mHtrans = DLB_TRANS_IDLE;
        mHsize = DLB_SIZE_WORD;
        waits = 4'h0;
        u_slave.mem[4] = 32'h0000_0800;
        u_slave.mem[5] = 32'hC3A5_96E7;
        repeat (16) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        apbXfer(DLB_CTRL_OFS, 1'b0, 32'h0, 32'h1, 1'b0);
        apbXfer(DLB_STAT_OFS, 1'b0, 32'h0, 32'h0, 1'b0);
        apbXfer(DLB_SET_CNT_OFS, 1'b0, 32'h0, DLB_CNT_RESET, 1'b0);
        apbXfer(12'h010, 1'b0, 32'h0, 32'h0, 1'b1);
        las(DLB_SIZE_BYTE, 1, 27);
        las(DLB_SIZE_HALF, 2, 29);
        las(DLB_SIZE_WORD, 0, 31);
        waits <= 4'h2;
        las(DLB_SIZE_WORD, 0, 0);
        unsigned_field_extract(DLB_SIZE_WORD, 0, 3, 0);
        waits <= 4'h0;
        unsigned_field_extract(DLB_SIZE_BYTE, 3, 5, 4);
        unsigned_field_extract(DLB_SIZE_HALF, 2, 9, 7);
        unsigned_field_extract(DLB_SIZE_WORD, 0, 20, 15);
        unsigned_field_extract(DLB_SIZE_WORD, 0, 4, 11);
        apbXfer(DLB_SET_CNT_OFS, 1'b0, 32'h0, 32'h4, 1'b0);
        apbXfer(DLB_EXT_CNT_OFS, 1'b0, 32'h0, 32'h5, 1'b0);
        apbXfer(DLB_CTRL_OFS, 1'b1, 32'h0, 32'h0, 1'b0);
        ahbRead(32'h4C00_0010, DLB_SIZE_WORD, 32'hA000_0801);
        `CHK(u_slave.lastAddr, 32'h4C00_0010)
        ahbRead(32'h4000_0014, DLB_SIZE_WORD, 32'hC3A5_96E7);
        finishTest();
    end
endmodule
